// >>> inc/pts_defines.svh
// Timing and layout constants of the panel timing and power sequencer.
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH
// Reference clock rate in kHz, cycles per millisecond.
`define PTS_REF_KHZ 100000
// Video raster, pixel clocks per line and lines per frame.
`define PTS_LINE_TOTAL 1440
`define PTS_LINE_ACTIVE 1280
`define PTS_FRAME_TOTAL 838
`define PTS_FRAME_ACTIVE 800
// Power sequence waits in milliseconds.
`define PTS_T2_MS 30
`define PTS_T3_MS 200
`define PTS_T5_MS 10
`define PTS_T6_MS 10
`define PTS_T8_MS 10
`define PTS_T10_MS 200
`define PTS_T11_MS 1
`define PTS_T13_MS 500
// Upper bounds kept for checking, in milliseconds.
`define PTS_T2_MAX_MS 90
`define PTS_T11_MAX_MS 50
// Dimming pulse: reference cycles per duty step, 256 steps a period.
`define PTS_PWM_STEP 40
`endif

// >>> inc/pts_pkg.sv
// Types shared by the panel timing and power sequencer.
package pts_pkg;
  // Power sequence states, one-hot.
  typedef enum logic [10:0] {
    PTS_OFF    = 11'h001,
    PTS_PWR    = 11'h002,
    PTS_VWAIT  = 11'h004,
    PTS_VON    = 11'h008,
    PTS_BLPWR  = 11'h010,
    PTS_BLGOOD = 11'h020,
    PTS_PWMON  = 11'h040,
    PTS_ON     = 11'h080,
    PTS_PWMOFF = 11'h100,
    PTS_VHOLD  = 11'h200,
    PTS_HOLD   = 11'h400
  } pts_state_e;
endpackage

// >>> verilog/pts_sequencer.sv
// Panel power sequencer and data-enable video timing generator.
`timescale 1ns/1ps
`include "pts_defines.svh"

module pts_sequencer import pts_pkg::*; #(
  // Width of the wait timer; it must hold the longest wait in cycles.
  parameter int TW = 26,
  // Minimum waits of the power sequence, in reference cycles.
  parameter int T2_CYC = `PTS_T2_MS * `PTS_REF_KHZ,
  parameter int T3_CYC = `PTS_T3_MS * `PTS_REF_KHZ,
  parameter int T5_CYC = `PTS_T5_MS * `PTS_REF_KHZ,
  parameter int T6_CYC = `PTS_T6_MS * `PTS_REF_KHZ,
  parameter int T8_CYC = `PTS_T8_MS * `PTS_REF_KHZ,
  parameter int T10_CYC = `PTS_T10_MS * `PTS_REF_KHZ,
  parameter int T11_CYC = `PTS_T11_MS * `PTS_REF_KHZ,
  parameter int T13_CYC = `PTS_T13_MS * `PTS_REF_KHZ,
  // Upper bounds of two waits, used only by the checks.
  parameter int T2_MAX_CYC = `PTS_T2_MAX_MS * `PTS_REF_KHZ,
  parameter int T11_MAX_CYC = `PTS_T11_MAX_MS * `PTS_REF_KHZ,
  // Raster of the video link, in pixel clocks and lines.
  parameter int LINE_TOTAL = `PTS_LINE_TOTAL,
  parameter int LINE_ACTIVE = `PTS_LINE_ACTIVE,
  parameter int FRAME_TOTAL = `PTS_FRAME_TOTAL,
  parameter int FRAME_ACTIVE = `PTS_FRAME_ACTIVE,
  // Width of one pixel word.
  parameter int DW = 24
) (
  // Reference clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Pixel clock of the video link.
  input wire logic pix_clk_in,
  // User control.
  input wire logic power_req_in,
  input wire logic [7:0] duty_in,
  // Supply good pins.
  input wire logic panel_pg_in,
  input wire logic bl_pg_in,
  // Pixel data from user logic on the pixel clock.
  input wire logic [DW-1:0] pixel_data_in,
  // Supply and backlight control pins.
  output logic panel_pwr_en_out,
  output logic bl_pwr_en_out,
  output logic bl_pwm_out,
  output logic bl_en_out,
  output logic self_test_out,
  // Sequence status.
  output logic seq_on_out,
  output logic seq_off_out,
  // Video link, pixel clock domain.
  output logic video_de_out,
  output logic frame_start_out,
  output logic [DW-1:0] pixel_data_out
);

  // Reference domain: sequence, timer and backlight pins.
  // Sequence state and the wait timer of the current state.
  pts_state_e state;
  pts_state_e next_state;
  logic [TW-1:0] tmr;
  logic [TW-1:0] wait_cyc;
  logic tmr_done;
  // Synchronisers for the supply good pins.
  logic panel_pg_s1, panel_pg_s2, bl_pg_s1, bl_pg_s2;
  // Video enable level handed to the pixel domain.
  logic vid_en;
  logic next_vid_en;
  // Dimming pulse generator.
  logic [7:0] pwm_pre;
  logic [7:0] pwm_phase;
  logic pwm_run;
  logic pre_wrap;

  // Supply good pins pass two flip-flops before use.
  always_ff @(posedge ref_clk_in) begin
    panel_pg_s1 <= panel_pg_in;
    panel_pg_s2 <= panel_pg_s1;
    bl_pg_s1 <= bl_pg_in;
    bl_pg_s2 <= bl_pg_s1;
  end

  // Wait length required in each state, zero where none.
  // States that wait for a supply pin have no timed wait; they hold
  // until the pin reports good, however long that takes.
  always_comb begin
    case (state)
      PTS_VWAIT: wait_cyc = TW'(T2_CYC);
      PTS_VON: wait_cyc = TW'(T3_CYC);
      PTS_BLGOOD: wait_cyc = TW'(T5_CYC);
      PTS_PWMON: wait_cyc = TW'(T6_CYC);
      PTS_PWMOFF: wait_cyc = TW'(T8_CYC);
      PTS_VHOLD: wait_cyc = TW'(T10_CYC);
      PTS_OFF: wait_cyc = TW'(T11_CYC);
      PTS_HOLD: wait_cyc = TW'(T13_CYC);
      default: wait_cyc = '0;
    endcase
  end
  // The timer stops at its target so a long stay cannot wrap it.
  assign tmr_done = (tmr >= wait_cyc);

  // Next state: power-down walks the power-up steps backwards.
  always_comb begin
    next_state = state;
    case (state)
      // Off after video is gone; supply stays until the short gap ends.
      PTS_OFF: if (tmr_done) next_state = PTS_HOLD;
      // Minimum off period, then wait for a request.
      PTS_HOLD: if (tmr_done && power_req_in) next_state = PTS_PWR;
      // Panel supply on, wait for it to report good.
      PTS_PWR: if (panel_pg_s2) next_state = PTS_VWAIT;
      // Video waits for the panel supply to settle.
      PTS_VWAIT: if (tmr_done) next_state = PTS_VON;
      // Backlight supply only after video has run long enough.
      PTS_VON: if (tmr_done) next_state = PTS_BLPWR;
      // Backlight supply on, wait for it to report good.
      PTS_BLPWR: if (bl_pg_s2) next_state = PTS_BLGOOD;
      // Dimming, then enable, each after its own wait.
      PTS_BLGOOD: if (tmr_done) next_state = PTS_PWMON;
      PTS_PWMON: if (tmr_done) next_state = PTS_ON;
      // Running; a dropped request starts the power-down.
      PTS_ON: if (!power_req_in) next_state = PTS_PWMOFF;
      // Enable and dimming stop together, supply goes after the wait.
      PTS_PWMOFF: if (tmr_done) next_state = PTS_VHOLD;
      // Video held with the backlight dark.
      PTS_VHOLD: if (tmr_done) next_state = PTS_OFF;
      default: next_state = PTS_HOLD;
    endcase
  end

  // Reset lands in the off hold so the minimum off period follows reset too.
  // State and timer; the timer restarts on every state change.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state <= PTS_HOLD;
      tmr <= '0;
    end else begin
      state <= next_state;
      tmr <= (next_state != state) ? '0 : (tmr_done ? tmr : tmr + 1'b1);
    end
  end

  // Output levels decoded from the next state so pins move with it.
  // Decoding the next state keeps every pin but bl_pwm_out one flop from the state
  // register, with no extra cycle of lag between a step and its pin.
  wire nx_panel = !(next_state inside {PTS_HOLD, PTS_OFF}) || (next_state == PTS_OFF
                  && state != PTS_HOLD);
  wire nx_vid = next_state inside {PTS_VON, PTS_BLPWR, PTS_BLGOOD, PTS_PWMON, PTS_ON,
                                   PTS_PWMOFF, PTS_VHOLD};
  wire nx_blpwr = next_state inside {PTS_BLPWR, PTS_BLGOOD, PTS_PWMON, PTS_ON,
                                     PTS_PWMOFF};
  wire nx_pwm = next_state inside {PTS_PWMON, PTS_ON};
  wire nx_blen = (next_state == PTS_ON);
  // The video level is registered before it crosses to the pixel domain.
  assign next_vid_en = nx_vid;

  // Control pins; all but seq_off_out low while the panel supply is off.
  // Reset drives every pin low, the safe level with the supply off.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      panel_pwr_en_out <= 1'b0;
      vid_en <= 1'b0;
      bl_pwr_en_out <= 1'b0;
      pwm_run <= 1'b0;
      bl_en_out <= 1'b0;
      self_test_out <= 1'b0;
      seq_on_out <= 1'b0;
      seq_off_out <= 1'b0;
    end else begin
      panel_pwr_en_out <= nx_panel;
      vid_en <= next_vid_en;
      bl_pwr_en_out <= nx_blpwr;
      pwm_run <= nx_pwm;
      bl_en_out <= nx_blen;
      self_test_out <= nx_panel;
      seq_on_out <= nx_blen;
      seq_off_out <= (next_state == PTS_HOLD);
    end
  end

  // Dimming pulse: prescaler then 256-step phase compared with duty.
  // Phase zero starts each period; a duty of zero keeps the pulse low.
  // Stopping the pulse clears the phase so each start is clean.
  assign pre_wrap = (pwm_pre == 8'(`PTS_PWM_STEP - 1));
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in || !pwm_run) begin
      pwm_pre <= 8'h00;
      pwm_phase <= 8'h00;
      bl_pwm_out <= 1'b0;
    end else begin
      pwm_pre <= pre_wrap ? 8'h00 : pwm_pre + 8'h01;
      pwm_phase <= pre_wrap ? pwm_phase + 8'h01 : pwm_phase;
      bl_pwm_out <= (pwm_phase < duty_in);
    end
  end

  // Pixel domain: reset and video enable each cross by two flip-flops.
  logic prst_s1, prst_s2, ven_s1, ven_s2;
  // Pixel position in the line and line in the frame.
  logic [10:0] hcnt;
  logic [9:0] vcnt;
  // Next data-enable level follows from the current position.
  wire pix_run = prst_s2 && ven_s2;
  wire line_end = (hcnt == 11'(LINE_TOTAL - 1));
  wire frame_end = (vcnt == 10'(FRAME_TOTAL - 1));
  wire next_de = (hcnt < 11'(LINE_ACTIVE)) && (vcnt < 10'(FRAME_ACTIVE));

  // Crossing into the pixel clock domain.
  // Both are slow levels, so two flops suffice; the raster restarts from
  // the top left corner each time video is enabled.
  always_ff @(posedge pix_clk_in) begin
    prst_s1 <= reset_n_in;
    prst_s2 <= prst_s1;
    ven_s1 <= vid_en;
    ven_s2 <= ven_s1;
  end

  // Raster counters; the pixel clock rate sets the refresh rate.
  // The line counter steps once per line, at the last pixel clock.
  always_ff @(posedge pix_clk_in) begin
    if (!pix_run) begin
      hcnt <= 11'h000;
      vcnt <= 10'h000;
    end else begin
      hcnt <= line_end ? 11'h000 : hcnt + 11'h001;
      vcnt <= !line_end ? vcnt : (frame_end ? 10'h000 : vcnt + 10'h001);
    end
  end

  // Link outputs: enable marks active pixels, data zero elsewhere.
  // The frame pulse marks the first active pixel of each frame.
  always_ff @(posedge pix_clk_in) begin
    if (!pix_run) begin
      video_de_out <= 1'b0;
      frame_start_out <= 1'b0;
      pixel_data_out <= '0;
    end else begin
      video_de_out <= next_de;
      frame_start_out <= (hcnt == 11'h000) && (vcnt == 10'h000);
      pixel_data_out <= next_de ? pixel_data_in : '0;
    end
  end

  // Helper ages: cycles since each watched level last changed.
  // Each age saturates, so a long stay never reads as a short one.
  // Bit order: panel enable, backlight enable, dimming run,
  // backlight good, video enable, panel good.
  logic [5:0] watch, watch_q;
  logic [TW-1:0] age [6];
  assign watch = {panel_pwr_en_out, bl_en_out, pwm_run, bl_pg_s2, vid_en, panel_pg_s2};
  always_ff @(posedge ref_clk_in) watch_q <= watch;
  for (genvar k = 0; k < 6; k++) begin : g_age
    always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in || watch[k] != watch_q[k]) age[k] <= '0;
      else if (age[k] != {TW{1'b1}}) age[k] <= age[k] + 1'b1;
    end
  end

  // All checks below run on the reference clock unless they name another.
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  // Quiet outputs with the supply off, then the power-up order.

  off_quiet_a: assert property (!panel_pwr_en_out |-> !vid_en && !bl_pwm_out && !bl_en_out
    && !self_test_out && !bl_pwr_en_out) else $error("output active with supply off");
  vid_delay_a: assert property ($rose(vid_en) |-> panel_pg_s2 && age[0] >= TW'(T2_CYC)
    && age[0] <= TW'(T2_MAX_CYC)) else $error("video valid outside window");
  bl_after_vid_a: assert property ($rose(bl_en_out) |-> vid_en && age[1] >= TW'(T3_CYC))
    else $error("backlight too soon after video");
  pwm_start_a: assert property ($rose(pwm_run) |-> bl_pg_s2 && age[2] >= TW'(T5_CYC))
    else $error("dimming started too soon");
  en_after_pwm_a: assert property ($rose(bl_en_out) |-> pwm_run && age[3] >= TW'(T6_CYC))
    else $error("enable too soon after dimming");
  // Power-down order.
  en_before_pwm_a: assert property ($fell(pwm_run) |-> !bl_en_out)
    else $error("dimming stopped before enable");
  blpwr_off_a: assert property ($fell(bl_pwr_en_out) |-> !pwm_run && age[3] >= TW'(T8_CYC))
    else $error("backlight supply removed too soon");
  vid_hold_a: assert property ($fell(vid_en) |-> !bl_en_out && age[4] >= TW'(T10_CYC))
    else $error("video disabled too soon");
  panel_off_a: assert property ($fell(panel_pwr_en_out) |-> !vid_en && age[1] >= TW'(T11_CYC)
    && age[1] <= TW'(T11_MAX_CYC)) else $error("panel supply off outside window");
  // Off period and overall order.
  min_off_a: assert property ($rose(panel_pwr_en_out) |-> age[5] >= TW'(T13_CYC))
    else $error("power-up inside off period");
  reverse_a: assert property (state == PTS_ON && !power_req_in |=> state == PTS_PWMOFF
    ##1 (state == PTS_PWMOFF)[*2]) else $error("power-down order broken");
  // Pixel domain.
  de_gate_a: assert property (@(posedge pix_clk_in) disable iff (!prst_s2)
    !ven_s2 |=> !video_de_out && pixel_data_out == '0) else $error("enable without video");

  // Further guards on the levels that stand between steps.
  en_needs_pwm_a: assert property (bl_en_out |-> pwm_run)
    else $error("enable high without dimming");
  pwm_gated_a: assert property (bl_pwm_out |-> $past(pwm_run))
    else $error("dimming pulse while stopped");
  blpwr_needs_vid_a: assert property (bl_pwr_en_out |-> vid_en && panel_pwr_en_out)
    else $error("backlight supply out of order");
  test_pin_a: assert property (self_test_out == panel_pwr_en_out)
    else $error("self-test pin not held high");
  vid_needs_panel_a: assert property ($rose(vid_en) |-> panel_pwr_en_out)
    else $error("video without panel supply");
  off_flag_a: assert property (seq_off_out |-> !panel_pwr_en_out)
    else $error("off flag with supply on");
  hold_keep_a: assert property (state == PTS_HOLD && tmr < TW'(T13_CYC)
    |=> state == PTS_HOLD)
    else $error("restart inside off period");
  line_wrap_a: assert property (@(posedge pix_clk_in) disable iff (!pix_run)
    line_end |=> hcnt == 11'h000) else $error("line length wrong");

  // Main scenarios reached by the runs.

  up_cov: cover property ($rose(seq_on_out));
  down_cov: cover property ($fell(panel_pwr_en_out));
  restart_cov: cover property ($rose(seq_off_out) ##[1:1000] state == PTS_PWR);
  de_cov: cover property (@(posedge pix_clk_in) $rose(video_de_out));
  blank_cov: cover property (@(posedge pix_clk_in) $fell(video_de_out));

endmodule

// >>> bench/pts_panel_model.sv
// Behavioural model of the display module that the sequencer drives.
`timescale 1ns/1ps
module pts_panel_model (
  // Clocks and the slow-supply choice.
  input wire logic ref_clk_in,
  input wire logic pix_clk_in,
  input wire logic slow_in,
  // Supply enables and the video link.
  input wire logic panel_pwr_en_in,
  input wire logic bl_pwr_en_in,
  input wire logic video_de_in,
  input wire logic frame_start_in,
  // Supply good pins and the framing the panel recovers.
  output logic panel_pg_out = 1'b0,
  output logic bl_pg_out = 1'b0,
  output int px_count_out,
  output int line_len_out,
  output int line_count_out
);
  int pc, bc, run, since, lines;
  logic de_q = 1'b0;
  // Supplies report good a while after their enables and drop at once when cut.
  always_ff @(posedge ref_clk_in) begin
    pc <= panel_pwr_en_in ? pc + 1 : 0;
    bc <= bl_pwr_en_in ? bc + 1 : 0;
    panel_pg_out <= panel_pwr_en_in && pc >= (slow_in ? 60 : 5);
    bl_pg_out <= bl_pwr_en_in && bc >= (slow_in ? 60 : 5);
  end
  // Line framing is taken from the data-enable qualifier; frame framing also uses the frame start pulse.
  always_ff @(posedge pix_clk_in) begin
    de_q <= video_de_in;
    run <= video_de_in ? run + 1 : 0;
    since <= (video_de_in && !de_q) ? 1 : since + 1;
    if (video_de_in && !de_q && !frame_start_in) line_len_out <= since;
    if (!video_de_in && de_q) begin
      px_count_out <= run;
      lines <= lines + 1;
    end
    if (frame_start_in) begin
      line_count_out <= lines;
      lines <= 0;
    end
  end
endmodule

// >>> bench/test_pts_sequencer.sv
// Self-checking bench of the panel sequencer against the display model.
`timescale 1ns/1ps
module test_pts_sequencer;
  localparam int T2 = 40, T2M = 80, T3 = 60, T5 = 20, T6 = 20, T8 = 20, T10 = 400;
  localparam int T11 = 30, T11M = 100, T13 = 50, LT = 20, LA = 16, FT = 6, FA = 4;
  localparam int LAG = 12, SLK = 150;
  logic ref_clk = 0, pix_clk = 0, reset_n = 0, req = 1, slow = 0;
  logic p_pg, b_pg, pwr, blp, pwm, en, st, son, soff, de, fs;
  logic [23:0] pin = 24'h0, d_last, pout;
  logic [5:0] q = 6'h0;
  int px, ll, lc, n_errors = 0, compares = 0, cyc = 0, pcyc = 0, t0, t_fs, fs_gap;
  int t_pwr, t_pg, t_de0 = -1, t_de1, t_blp, t_blpg, t_pwm, t_en, t_enoff, t_blpoff, t_poff;
  int t_pwmoff;
  always #5 ref_clk = ~ref_clk;
  // The pixel clock is offset so its edges never meet a reference edge; its period is three reference periods.
  initial begin
    #7;
    forever #15 pix_clk = ~pix_clk;
  end
  pts_sequencer #(.T2_CYC(T2), .T3_CYC(T3), .T5_CYC(T5), .T6_CYC(T6), .T8_CYC(T8),
    .T10_CYC(T10), .T11_CYC(T11), .T13_CYC(T13), .T2_MAX_CYC(T2M), .T11_MAX_CYC(T11M),
    .LINE_TOTAL(LT), .LINE_ACTIVE(LA), .FRAME_TOTAL(FT), .FRAME_ACTIVE(FA)) pts_sequencer_inst (
    .ref_clk_in(ref_clk), .reset_n_in(reset_n), .pix_clk_in(pix_clk), .power_req_in(req),
    .duty_in(8'hff), .panel_pg_in(p_pg), .bl_pg_in(b_pg), .pixel_data_in(pin),
    .panel_pwr_en_out(pwr), .bl_pwr_en_out(blp), .bl_pwm_out(pwm), .bl_en_out(en),
    .self_test_out(st), .seq_on_out(son), .seq_off_out(soff), .video_de_out(de),
    .frame_start_out(fs), .pixel_data_out(pout));
  pts_panel_model pts_panel_model_inst (.ref_clk_in(ref_clk), .pix_clk_in(pix_clk),
    .slow_in(slow), .panel_pwr_en_in(pwr), .bl_pwr_en_in(blp), .video_de_in(de),
    .frame_start_in(fs), .panel_pg_out(p_pg), .bl_pg_out(b_pg), .px_count_out(px),
    .line_len_out(ll), .line_count_out(lc));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task final_report;
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Edge times of the supply, good, dimming and enable pins, in reference cycles, plus the hang limit.
  always @(negedge ref_clk) begin
    cyc++;
    if (pwr && !q[0]) t_pwr = cyc;
    if (!pwr && q[0]) t_poff = cyc;
    if (p_pg && !q[1]) t_pg = cyc;
    if (blp && !q[2]) t_blp = cyc;
    if (!blp && q[2]) t_blpoff = cyc;
    if (b_pg && !q[3]) t_blpg = cyc;
    if (pwm && !q[4]) t_pwm = cyc;
    if (en && !q[5]) t_en = cyc;
    if (!en && q[5]) t_enoff = cyc;
    if (!pwm && q[4]) t_pwmoff = cyc;
    q = {en, pwm, b_pg, blp, p_pg, pwr};
    if (cyc > 20000) begin
      n_errors++;
      final_report;
    end
  end
  // Pixel source and the per-pixel data and frame spacing checks.
  always @(posedge pix_clk) begin
    d_last <= pin;
    pin <= #1 pin + 24'h1;
  end
  always @(negedge pix_clk) begin
    pcyc++;
    if (reset_n) check("pixel_data", pout, de ? d_last : 24'h0);
    if (de) t_de1 = cyc;
    if (de && t_de0 < 0) t_de0 = cyc;
    if (fs) begin
      fs_gap = pcyc - t_fs;
      t_fs = pcyc;
    end
  end
  task reset_hold;
    repeat (20) @(posedge ref_clk);
    #1 reset_n = 1;
    t0 = cyc;
    repeat (T13 - 2) @(posedge ref_clk);
    #1 check("early_power", {pwr, st, de, soff}, 4'h1);
    wait (pwr === 1'b1);
    @(negedge ref_clk);
    #1 check("off_after_reset", t_pwr - t0 >= T13, 1);
  endtask
  task power_up;
    wait (son === 1'b1);
    @(negedge ref_clk);
    #1 check("video_min", t_de0 - t_pg >= T2, 1);
    check("video_max", t_de0 - t_pg <= T2M, 1);
    check("bl_after_video", t_blp - t_de0 >= T3 - LAG, 1);
    check("pwm_after_blpg", t_pwm - t_blpg >= T5, 1);
    check("en_after_pwm", t_en - t_pwm >= T6, 1);
    check("self_test_high", st, 1);
  endtask
  task raster;
    repeat (1500) @(posedge ref_clk);
    #1 check("active_pixels", px, LA);
    check("line_total", ll, LT);
    check("active_lines", lc, FA);
    check("frame_total", fs_gap, LT * FT);
  endtask
  task power_down;
    @(posedge ref_clk);
    #1 req = 0;
    wait (soff === 1'b1);
    @(negedge ref_clk);
    #1 check("bl_supply_hold", t_blpoff - t_enoff >= T8, 1);
    check("pwm_at_enable_off", t_pwmoff >= t_enoff, 1);
    check("video_hold", t_de1 - t_blpoff >= T10 - SLK, 1);
    check("panel_off_after", t_poff > t_de1 && t_poff - t_de1 <= T11M + SLK, 1);
    check("outputs_low", {pwr, blp, pwm, en, st, de}, 0);
  endtask
  task restart;
    @(posedge ref_clk);
    #1 slow = 1;
    req = 1;
    t_de0 = -1;
    wait (pwr === 1'b1);
    @(negedge ref_clk);
    #1 check("off_period", t_pwr - t_poff >= T13, 1);
  endtask
  initial begin
    reset_hold;
    power_up;
    raster;
    power_down;
    restart;
    power_up;
    final_report;
  end
endmodule
